// *** sdr_consts.svh ***
/*
 * Constants of the sense data reporter: command codes, status codes,
 * register offsets, field positions and record lengths.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

`define SDR_OP_SENSE 8'h03
`define SDR_OP_DIAG 8'h1C
`define SDR_STAT_GOOD 8'h00
`define SDR_STAT_CHECK 8'h02

`define SDR_CODE_CURRENT 7'h70
`define SDR_CODE_DEFERRED 7'h71

`define SDR_CDB_LEN 3'h6
`define SDR_SENSE_LEN 5'h12
`define SDR_ADD_SENSE_LEN 8'h0A
`define SDR_DIAG_BYTES 16
`define SDR_DIAG_WORDS 4

`define SDR_REG_CTRL 8'h00
`define SDR_REG_STATUS 8'h04
`define SDR_REG_SENSE_A 8'h08
`define SDR_REG_SENSE_INFO 8'h0C
`define SDR_REG_SENSE_CSI 8'h10
`define SDR_REG_SENSE_B 8'h14
`define SDR_REG_POST 8'h18
`define SDR_REG_DIAG_CFG 8'h1C
`define SDR_REG_DIAG_BUF0 8'h20

`define SDR_CTRL_SEQ_BIT 0
`define SDR_CTRL_PRN_BIT 1
`define SDR_CTRL_PAGE_BIT 2
`define SDR_CTRL_DEFER_BIT 3

`define SDR_SA_KEY_MSB 3
`define SDR_SA_ILI_BIT 4
`define SDR_SA_EOM_BIT 5
`define SDR_SA_FM_BIT 6
`define SDR_SA_VALID_BIT 7

`define SDR_POST_SET_BIT 0
`define SDR_POST_CLR_BIT 1

`endif

// *** sdr_pkg.sv ***
/*
 * Types of the sense data reporter.
 * Assumes the constants header sits in the same folder.
 */
package sdr_pkg;
	`include "sdr_consts.svh"

	typedef enum logic [1:0] {
		SDR_IDLE = 2'b00,
		SDR_CDB = 2'b01,
		SDR_SEND = 2'b10,
		SDR_STAT = 2'b11
	} sdr_state_t;

	typedef logic [7:0] sdr_byte_t;
endpackage : sdr_pkg

// *** sdr_core.sv ***
/*
 * Target-side interpreter for the sense request and the diagnostic
 * results request: takes command bytes, streams data-in bytes and
 * reports a status byte; sense fields and diagnostic results are
 * loaded by local firmware over a plain register port.
 * Assumes one initiator-target nexus per instance and all inputs
 * synchronous to clock.
 */
//
// Operation
// - Diagnostic results follow the page code of the preceding self-test command.
// - Sense request is six bytes, opcode 03h, allocation length byte 4.
// - Sense is held on contingent allegiance or other pending information.
// - Without held sense, return NO SENSE and no additional information.
// - Held sense survives until any next command on the nexus clears it.
// - CHECK CONDITION only for reserved bits, parity error or malfunction.
// - Recovered error during a sense request still ends with GOOD.
// - At least eighteen sense bytes can be delivered.
// - Additional sense length is never reduced by truncation.
// - Error code 70h current, 71h deferred optional.
// - Byte 0 holds valid flag in bit 7, error code below.
// - Valid flag set only when information field holds defined content.
// - Byte 7 holds record length minus eight.
// - Fixed byte layout of information, detail codes and key-specific data.
// - Segment number reports current copy segment, zero based.
// - Filemark flag only on sequential devices, reserved otherwise.
// - End-of-medium flag only on sequential or printer devices.
// - Length-mismatch flag marks block length differing from medium.
`timescale 1ns/10ps
`default_nettype none
`include "sdr_consts.svh"

module sdr_core
	import sdr_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_enable,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic cdb_valid,
	input wire logic cdb_first,
	input wire sdr_pkg::sdr_byte_t cdb_byte,
	output logic cdb_ready,
	output logic din_valid,
	output sdr_pkg::sdr_byte_t din_byte,
	input wire logic din_ready,
	output logic status_valid,
	output sdr_pkg::sdr_byte_t status_code,
	input wire logic parity_error,
	input wire logic recovered_error,
	input wire logic malfunction,
	output logic busy
);
	import sdr_pkg::*;

	sdr_state_t state_q;
	logic [3:0] ctrl_q;
	logic [31:0] sense_a_q;
	logic [31:0] sense_info_q;
	logic [31:0] sense_csi_q;
	logic [31:0] sense_b_q;
	logic [4:0] diag_len_q;
	logic [7:0] diag_page_q;
	logic [31:0] diag_word_q [0:`SDR_DIAG_WORDS-1];
	logic sense_held_q;
	logic snap_held_q;
	logic [7:0] cdb_q [0:5];
	logic [2:0] cdb_idx_q;
	logic is_diag_q;
	logic fault_q;
	logic last_check_q;
	logic [15:0] count_q;
	logic [15:0] idx_q;
	logic [31:0] rdata_q;
	sdr_byte_t din_byte_q;
	sdr_byte_t status_q;

	logic start_cmd;
	logic cdb_take;
	logic cdb_done;
	logic din_take;
	logic post_set;
	logic post_clr;
	logic reserved_bad;
	logic [15:0] alloc_len;
	logic [15:0] avail_len;

	// Sense record byte at index i
	function automatic sdr_byte_t sense_byte(input logic [15:0] i);
		sdr_byte_t b;
		logic seq;
		logic prn;
		b = 8'h00;
		seq = ctrl_q[`SDR_CTRL_SEQ_BIT];
		prn = ctrl_q[`SDR_CTRL_PRN_BIT];
		case (i)
			16'h0000: begin
				b = {snap_held_q & sense_a_q[`SDR_SA_VALID_BIT],
					ctrl_q[`SDR_CTRL_DEFER_BIT] ? `SDR_CODE_DEFERRED : `SDR_CODE_CURRENT};
			end
			16'h0001: b = sense_a_q[15:8];
			16'h0002: begin
				b = {sense_a_q[`SDR_SA_FM_BIT] & seq,
					sense_a_q[`SDR_SA_EOM_BIT] & (seq | prn),
					sense_a_q[`SDR_SA_ILI_BIT],
					1'b0,
					sense_a_q[`SDR_SA_KEY_MSB:0]};
			end
			16'h0003: b = sense_info_q[31:24];
			16'h0004: b = sense_info_q[23:16];
			16'h0005: b = sense_info_q[15:8];
			16'h0006: b = sense_info_q[7:0];
			16'h0007: b = `SDR_ADD_SENSE_LEN;
			16'h0008: b = sense_csi_q[31:24];
			16'h0009: b = sense_csi_q[23:16];
			16'h000A: b = sense_csi_q[15:8];
			16'h000B: b = sense_csi_q[7:0];
			16'h000C: b = sense_a_q[23:16];
			16'h000D: b = sense_a_q[31:24];
			16'h000E: b = sense_b_q[7:0];
			16'h000F: b = sense_b_q[31:24];
			16'h0010: b = sense_b_q[23:16];
			16'h0011: b = sense_b_q[15:8];
			default: b = 8'h00;
		endcase
		// Nothing held: current code, zero key and detail codes, length remains
		if (!snap_held_q) begin
			if (i == 16'h0000) begin
				b = {1'b0, `SDR_CODE_CURRENT};
			end else if (i != 16'h0007) begin
				b = 8'h00;
			end
		end
		return b;
	endfunction : sense_byte

	// Diagnostic result byte at index i
	function automatic sdr_byte_t diag_byte(input logic [15:0] i);
		sdr_byte_t b;
		logic [31:0] w;
		w = diag_word_q[i[3:2]];
		// Big-endian words: lowest byte index in bits 31:24
		case (i[1:0])
			2'h0: b = w[31:24];
			2'h1: b = w[23:16];
			2'h2: b = w[15:8];
			default: b = w[7:0];
		endcase
		if (i == 16'h0000 && ctrl_q[`SDR_CTRL_PAGE_BIT]) begin
			b = diag_page_q;
		end
		return b;
	endfunction : diag_byte

	function automatic sdr_byte_t next_byte(input logic [15:0] i);
		return is_diag_q ? diag_byte(i) : sense_byte(i);
	endfunction : next_byte

	assign cdb_ready = (state_q == SDR_IDLE) || (state_q == SDR_CDB);
	assign start_cmd = clock_enable && cdb_valid && cdb_first && state_q == SDR_IDLE;
	assign cdb_take = clock_enable && cdb_valid && state_q == SDR_CDB;
	assign cdb_done = cdb_take && cdb_idx_q == `SDR_CDB_LEN - 3'h1;
	assign din_valid = state_q == SDR_SEND;
	assign din_take = clock_enable && din_valid && din_ready;
	assign din_byte = din_byte_q;
	assign status_valid = state_q == SDR_STAT;
	assign status_code = status_q;
	assign reg_rdata = rdata_q;
	assign busy = state_q != SDR_IDLE;
	assign post_set = reg_write && reg_addr == `SDR_REG_POST && reg_wdata[`SDR_POST_SET_BIT];
	assign post_clr = reg_write && reg_addr == `SDR_REG_POST && reg_wdata[`SDR_POST_CLR_BIT];

	// Reserved fields and lengths of the command from captured bytes 1 to 4; the last byte is not checked
	always_comb begin
		if (is_diag_q) begin
			reserved_bad = (cdb_q[1][4:0] != 5'h00) || (cdb_q[2] != 8'h00);
			alloc_len = {cdb_q[3], cdb_q[4]};
			avail_len = {11'h000, diag_len_q};
		end else begin
			reserved_bad = (cdb_q[1][4:0] != 5'h00) || (cdb_q[2] != 8'h00)
				|| (cdb_q[3] != 8'h00);
			alloc_len = {8'h00, cdb_q[4]};
			avail_len = {11'h000, `SDR_SENSE_LEN};
		end
	end

	// Command byte capture; logical unit is not decoded here
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cdb_idx_q <= 3'h0;
			is_diag_q <= 1'b0;
			for (int k = 0; k < 6; k++) begin
				cdb_q[k] <= 8'h00;
			end
		end else if (start_cmd) begin
			cdb_q[0] <= cdb_byte;
			cdb_idx_q <= 3'h1;
			is_diag_q <= cdb_byte == `SDR_OP_DIAG;
		end else if (cdb_take) begin
			cdb_q[cdb_idx_q] <= cdb_byte;
			cdb_idx_q <= cdb_idx_q + 3'h1;
		end
	end

	// Held sense: set by firmware, cleared by any command on the nexus.
	// Firmware posting in the same cycle wins so a new condition is never lost.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sense_held_q <= 1'b0;
			snap_held_q <= 1'b0;
		end else if (clock_enable) begin
			if (start_cmd) begin
				snap_held_q <= sense_held_q;
			end
			if (post_set) begin
				sense_held_q <= 1'b1;
			end else if (start_cmd || post_clr) begin
				sense_held_q <= 1'b0;
			end
		end
	end

	// Command sequencing and status
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= SDR_IDLE;
			count_q <= 16'h0000;
			idx_q <= 16'h0000;
			fault_q <= 1'b0;
			din_byte_q <= 8'h00;
			status_q <= `SDR_STAT_GOOD;
			last_check_q <= 1'b0;
		end else if (clock_enable) begin
			case (state_q)
				SDR_IDLE: begin
					fault_q <= 1'b0;
					if (start_cmd) begin
						if (cdb_byte == `SDR_OP_SENSE || cdb_byte == `SDR_OP_DIAG) begin
							state_q <= SDR_CDB;
						end
					end
				end
				SDR_CDB: begin
					if (parity_error) begin
						fault_q <= 1'b1;
					end
					if (cdb_done) begin
						idx_q <= 16'h0000;
						din_byte_q <= next_byte(16'h0000);
						if (reserved_bad || parity_error || fault_q
							|| (!is_diag_q && malfunction)) begin
							status_q <= `SDR_STAT_CHECK;
							state_q <= SDR_STAT;
						end else begin
							count_q <= alloc_len < avail_len ? alloc_len : avail_len;
							status_q <= `SDR_STAT_GOOD;
							if (alloc_len == 16'h0000 || avail_len == 16'h0000) begin
								state_q <= SDR_STAT;
							end else begin
								state_q <= SDR_SEND;
							end
						end
					end
				end
				SDR_SEND: begin
					// A recovered error does not alter the status
					if (parity_error) begin
						fault_q <= 1'b1;
					end
					if (din_take) begin
						idx_q <= idx_q + 16'h0001;
						din_byte_q <= next_byte(idx_q + 16'h0001);
						if (idx_q + 16'h0001 == count_q) begin
							state_q <= SDR_STAT;
							if (fault_q || parity_error) begin
								status_q <= `SDR_STAT_CHECK;
							end else begin
								status_q <= `SDR_STAT_GOOD;
							end
						end
					end
				end
				SDR_STAT: begin
					last_check_q <= status_q == `SDR_STAT_CHECK;
					state_q <= SDR_IDLE;
				end
				default: state_q <= SDR_IDLE;
			endcase
		end
	end

	// Firmware-written configuration and sense fields
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl_q <= 4'h0;
			sense_a_q <= 32'h00000000;
			sense_info_q <= 32'h00000000;
			sense_csi_q <= 32'h00000000;
			sense_b_q <= 32'h00000000;
			diag_len_q <= 5'h00;
			diag_page_q <= 8'h00;
		end else if (clock_enable && reg_write) begin
			case (reg_addr)
				`SDR_REG_CTRL: ctrl_q <= reg_wdata[3:0];
				`SDR_REG_SENSE_A: sense_a_q <= reg_wdata;
				`SDR_REG_SENSE_INFO: sense_info_q <= reg_wdata;
				`SDR_REG_SENSE_CSI: sense_csi_q <= reg_wdata;
				`SDR_REG_SENSE_B: sense_b_q <= reg_wdata;
				`SDR_REG_DIAG_CFG: begin
					diag_len_q <= reg_wdata[4:0] > 5'h10 ? 5'h10 : reg_wdata[4:0];
					diag_page_q <= reg_wdata[15:8];
				end
				default: ;
			endcase
		end
	end

	// Diagnostic result buffer; one word per process keeps one driver per element
	generate
		for (genvar w = 0; w < `SDR_DIAG_WORDS; w++) begin : g_diag
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					diag_word_q[w] <= 32'h00000000;
				end else if (clock_enable && reg_write
					&& reg_addr == `SDR_REG_DIAG_BUF0 + 8'(w * 4)) begin
					diag_word_q[w] <= reg_wdata;
				end
			end
		end
	endgenerate

	// Read data stands in the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
		end else if (clock_enable) begin
			rdata_q <= 32'h00000000;
			if (reg_read) begin
				case (reg_addr)
					`SDR_REG_CTRL: rdata_q <= {28'h0000000, ctrl_q};
					`SDR_REG_STATUS: rdata_q <= {16'h0000, cdb_q[0], 4'h0,
						last_check_q, recovered_error, busy, sense_held_q};
					`SDR_REG_SENSE_A: rdata_q <= sense_a_q;
					`SDR_REG_SENSE_INFO: rdata_q <= sense_info_q;
					`SDR_REG_SENSE_CSI: rdata_q <= sense_csi_q;
					`SDR_REG_SENSE_B: rdata_q <= sense_b_q;
					`SDR_REG_DIAG_CFG: rdata_q <= {16'h0000, diag_page_q, 3'h0, diag_len_q};
					default: rdata_q <= 32'h00000000;
				endcase
			end
		end
	end
endmodule : sdr_core

`default_nettype wire

// *** sdr_core_asserts.sv ***
/* Port checker for sdr_core, bound after the module.
 Assumes clock_enable is held high by the bench. */
`timescale 1ns/10ps
`default_nettype none
module sdr_core_asserts
	import sdr_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic cdb_valid,
	input wire logic cdb_first,
	input wire sdr_pkg::sdr_byte_t cdb_byte,
	input wire logic cdb_ready,
	input wire logic din_valid,
	input wire sdr_pkg::sdr_byte_t din_byte,
	input wire logic din_ready,
	input wire logic status_valid,
	input wire sdr_pkg::sdr_byte_t status_code,
	input wire logic parity_error,
	input wire logic busy
);
	sdr_byte_t op_q;
	logic [4:0] idx_q;
	logic perr_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			op_q <= 8'h00;
		end else if (cdb_valid && cdb_first && !busy) begin
			op_q <= cdb_byte;
		end
	end
	// Byte index and parity history restart with every status
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			idx_q <= 5'h00;
			perr_q <= 1'b0;
		end else if (status_valid) begin
			idx_q <= 5'h00;
			perr_q <= 1'b0;
		end else begin
			idx_q <= idx_q + 5'(din_valid && din_ready);
			perr_q <= perr_q | (parity_error && busy);
		end
	end
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (reset);
	a_idle_ready: assert property (!busy |-> cdb_ready && !din_valid)
		else $error("idle but not ready");
	a_cmd_start: assert property (cdb_valid && cdb_first && !busy && cdb_byte == 8'h03 |=> busy)
		else $error("sense opcode not taken");
	a_din_hold: assert property (din_valid && !din_ready |=> din_valid && $stable(din_byte))
		else $error("offered byte dropped");
	a_sense_code: assert property (din_valid && op_q == 8'h03 && idx_q == 5'h00 |->
		din_byte[6:0] inside {7'h70, 7'h71}) else $error("bad error code");
	a_add_len: assert property (din_valid && op_q == 8'h03 && idx_q == 5'h07 |-> din_byte == 8'h0A)
		else $error("bad additional length");
	a_sense_max: assert property (din_valid && op_q == 8'h03 |-> idx_q < 5'h12)
		else $error("sense record too long");
	a_stat_pulse: assert property (status_valid |=> !status_valid && !busy)
		else $error("status not one cycle");
	a_parity_check: assert property (status_valid && perr_q |-> status_code == 8'h02)
		else $error("parity fault not reported");
	c_sense: cover property (din_valid && din_ready && op_q == 8'h03);
	c_diag: cover property (din_valid && din_ready && op_q == 8'h1C);
	c_check: cover property (status_valid && status_code == 8'h02);
endmodule : sdr_core_asserts
bind sdr_core sdr_core_asserts u_sdr_core_asserts (.clock(clock), .reset(reset),
	.cdb_valid(cdb_valid), .cdb_first(cdb_first), .cdb_byte(cdb_byte), .cdb_ready(cdb_ready),
	.din_valid(din_valid), .din_byte(din_byte), .din_ready(din_ready),
	.status_valid(status_valid), .status_code(status_code),
	.parity_error(parity_error), .busy(busy));
`default_nettype wire

// *** sdr_initiator.sv ***
/* Initiator model: sends command bytes, takes data-in bytes.
 Assumes the bench calls send_cmd just after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module sdr_initiator
	import sdr_pkg::*;
(
	input wire logic clock,
	input wire logic cdb_ready,
	input wire logic stall,
	output logic cdb_valid,
	output logic cdb_first,
	output sdr_pkg::sdr_byte_t cdb_byte,
	output logic din_ready
);
	integer seed = 59;
	initial begin
		cdb_valid = 1'b0;
		cdb_first = 1'b0;
		cdb_byte = 8'h00;
	end
	// Random stalls test that an offered byte holds
	always @(posedge clock) begin
		din_ready <= stall ? 1'($random(seed)) : 1'b1;
	end
	task automatic send_cmd(input sdr_byte_t b[6]);
		for (int i = 0; i < 6; i++) begin
			cdb_valid <= 1'b1;
			cdb_first <= (i == 0);
			cdb_byte <= b[i];
			@(posedge clock);
			while (!cdb_ready) @(posedge clock);
		end
		cdb_valid <= 1'b0;
		cdb_first <= 1'b0;
		// Released bus must not look like the last byte
		cdb_byte <= ~b[5];
	endtask : send_cmd
endmodule : sdr_initiator
`default_nettype wire

// *** test_sense_data_reporter.sv ***
/* Bench for sdr_core: registers, sense and diagnostic transfers.
 Assumes sdr_initiator as far side and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_sense_data_reporter;
	import sdr_pkg::*;
	logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, rd_q = 1'b0;
	logic parity_error = 1'b0, recovered_error = 1'b0, malfunction = 1'b0, stall = 1'b0;
	logic cdb_valid, cdb_first, cdb_ready, din_valid, din_ready, status_valid, busy;
	logic held = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, sa, info, csi, sb, exp_reg[$];
	sdr_byte_t cdb_byte, din_byte, status_code, page, ctrl, dbuf[16], exp_din[$], exp_stat[$];
	integer n_mismatch = 0, check_count = 0, cycles = 0, seed = 59;
	sdr_core u_sdr_core (.clock(clock), .reset(reset), .clock_enable(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .cdb_valid(cdb_valid),
		.cdb_first(cdb_first), .cdb_byte(cdb_byte), .cdb_ready(cdb_ready),
		.din_valid(din_valid), .din_byte(din_byte), .din_ready(din_ready),
		.status_valid(status_valid), .status_code(status_code),
		.parity_error(parity_error), .recovered_error(recovered_error),
		.malfunction(malfunction), .busy(busy));
	sdr_initiator init (.clock(clock), .cdb_ready(cdb_ready), .stall(stall),
		.cdb_valid(cdb_valid), .cdb_first(cdb_first), .cdb_byte(cdb_byte), .din_ready(din_ready));
	initial begin
		forever #50 clock = ~clock;
	end
	task automatic stop_test();
		$display("Mismatches %0d of %0d checks", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp
	always @(posedge clock) begin
		cycles++;
		rd_q <= reg_read;
		if (din_valid && din_ready)
			cmp(din_byte, exp_din.size() > 0 ? exp_din.pop_front() : 32'hXXXXXXXX, "data");
		if (status_valid)
			cmp(status_code, exp_stat.size() > 0 ? exp_stat.pop_front() : 32'hXXXXXXXX, "status");
		if (rd_q)
			cmp(reg_rdata, exp_reg.size() > 0 ? exp_reg.pop_front() : 32'hXXXXXXXX, "reg");
		if (cycles > 6000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_reg.push_back(e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
	endtask : rd
	function automatic sdr_byte_t sbyte(input int i);
		sdr_byte_t r[18];
		r = '{default: 8'h00};
		r[0] = 8'h70;
		r[7] = 8'h0A;
		if (held) begin
			r[0] = {sa[7], ctrl[3] ? 7'h71 : 7'h70};
			r[1] = sa[15:8];
			r[2] = {sa[6] & ctrl[0], sa[5] & |ctrl[1:0], sa[4], 1'b0, sa[3:0]};
			{r[3], r[4], r[5], r[6]} = info;
			{r[8], r[9], r[10], r[11]} = csi;
			{r[14], r[13], r[12]} = {sb[7:0], sa[31:16]};
			{r[15], r[16], r[17]} = sb[31:8];
		end
		return r[i];
	endfunction : sbyte
	task automatic issue(input sdr_byte_t c[6]);
		stall <= 1'($random(seed));
		held = 1'b0;
		init.send_cmd(c);
		repeat (300) begin
			@(posedge clock);
			if (status_valid) break;
		end
	endtask : issue
	task automatic sense(input sdr_byte_t al, input sdr_byte_t rsv, input sdr_byte_t st);
		int n;
		n = (st != 8'h00) ? 0 : ((al > 8'h12) ? 18 : int'(al));
		for (int i = 0; i < n; i++) exp_din.push_back(sbyte(i));
		exp_stat.push_back(st);
		issue('{8'h03, {3'($random(seed)), 5'h00}, rsv, 8'h00, al, 8'h00});
	endtask : sense
	task automatic diag(input logic [15:0] al);
		for (int i = 0; i < al && i < 16; i++) exp_din.push_back((i == 0 && ctrl[2]) ? page : dbuf[i]);
		exp_stat.push_back(8'h00);
		issue('{8'h1C, 8'h00, 8'h00, al[15:8], al[7:0], 8'h00});
	endtask : diag
	initial begin
		sdr_byte_t al[5] = '{8'h00, 8'h02, 8'h08, 8'h12, 8'hFF};
		sdr_byte_t cv[4] = '{8'h01, 8'h00, 8'h02, 8'h09};
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		rd(8'hFC, 32'h0);
		rd(8'h04, 32'h0);
		foreach (al[i]) sense(al[i], 8'h00, 8'h00);
		foreach (cv[i]) begin
			ctrl = cv[i];
			{sa, info, csi, sb} = {$random(seed), $random(seed), $random(seed), $random(seed)};
			wr(8'h00, {24'h0, ctrl});
			wr(8'h08, sa);
			wr(8'h0C, info);
			wr(8'h10, csi);
			wr(8'h14, sb);
			wr(8'h18, 32'h1);
			held = 1'b1;
			rd(8'h04, 32'h0301);
			sense(i == 1 ? 8'h09 : 8'hFF, 8'h00, 8'h00);
		end
		sense(8'h12, 8'h00, 8'h00);
		wr(8'h18, 32'h1);
		issue('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		sense(8'h12, 8'h00, 8'h00);
		sense(8'h12, 8'h01, 8'h02);
		parity_error <= 1'b1;
		sense(8'h12, 8'h00, 8'h02);
		parity_error <= 1'b0;
		malfunction <= 1'b1;
		sense(8'h12, 8'h00, 8'h02);
		malfunction <= 1'b0;
		recovered_error <= 1'b1;
		rd(8'h04, 32'h030C);
		sense(8'h12, 8'h00, 8'h00);
		recovered_error <= 1'b0;
		foreach (dbuf[i]) dbuf[i] = 8'($random(seed));
		page = 8'($random(seed));
		for (int w = 0; w < 16; w += 4) wr(8'h20 + 8'(w), {dbuf[w], dbuf[w+1], dbuf[w+2], dbuf[w+3]});
		wr(8'h1C, {16'h0, page, 8'h10});
		ctrl = 8'h04;
		wr(8'h00, 32'h4);
		diag(16'h0100);
		diag(16'h0005);
		ctrl = 8'h00;
		wr(8'h00, 32'h0);
		diag(16'h0003);
		rd(8'h00, 32'h0);
		repeat (3) @(posedge clock);
		cmp(exp_din.size() + exp_stat.size() + exp_reg.size(), 0, "leftover");
		stop_test();
	end
endmodule : test_sense_data_reporter
`default_nettype wire
